// File: hw/cmo_unit.sv
// Contract
// - va is base plus sign-extended offset
// - translate va via tlb; sub-opcode picks variation
// - data cache block from va 13:5
// - instruction cache block from va 13:6
// - primary index ops take way from va bit 0
// - low va bits pick word in block
// - secondary index from pa; way pa bit 0
// - pa block-1 down to 3 picks doubleword
// - coprocessor unusable raises unusable exception
// - tlb refill/invalid allowed, never tlb modified
// - hit ops act only on valid match
// - no watch exception for these ops
// - index ops: ignore bit 0, check bit 1
// - other ops: both low bits must be zero
// - address errors from privilege and the low-bit checks only
// - primary writebacks to secondary, secondary to system
// - probe primary, copy dirty before system writeback
// - writeback address comes from stored tag
// - two low sub-opcode bits pick target cache
`timescale 1ns/1ps
module cmo_unit import cmo_pkg::*; #(
  parameter int L2_SIZE_LOG2 = 22,
  parameter int L2_BLK_LOG2  = 7
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pipeline issue and completion
  input  wire logic         issue_valid,
  output logic              issue_ready,
  input  wire cmo_issue_s   issue,
  input  wire logic         kernel_mode,
  input  wire logic         system_coproc_usable_bit,
  output logic              done_valid,
  output cmo_done_s         done,
  output logic              watch_suppress,
  // translation
  output logic              tlb_req_valid,
  output cmo_tlb_req_s      tlb_req,
  input  wire logic         tlb_rsp_valid,
  input  wire cmo_tlb_rsp_s tlb_rsp,
  // cache arrays
  output logic              arr_req_valid,
  output cmo_arr_cmd_s      arr_cmd,
  input  wire logic         arr_rsp_valid,
  input  wire cmo_arr_rsp_s arr_rsp,
  // primary to secondary writeback
  output logic              p2s_valid,
  output cmo_wb_s           p2s_wb,
  input  wire logic         p2s_ack,
  // secondary to system interface writeback
  output logic              sys_valid,
  output cmo_wb_s           sys_wb,
  input  wire logic         sys_ack
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;   // release shift
  logic       rst_n;   // synchronised reset

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle, st_check, st_tlb, st_look, st_probe, st_p2s, st_sys, st_act, st_done
  } cmo_state_e;

  cmo_state_e   state,    next_state;    // sequencer
  logic [4:0]   op,       next_op;       // captured sub-opcode
  cmo_va_t      va,       next_va;       // effective address
  cmo_pa_t      pa,       next_pa;       // translated address
  logic         way,      next_way;      // way for perform
  logic         need_sys, next_need_sys; // secondary block dirty
  cmo_wb_s      wb,       next_wb;       // writeback target
  cmo_exc_e     exc,      next_exc;      // completion exception
  cmo_arr_cmd_s cmd,      next_cmd;      // array command

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [1:0] sel;       // target cache
  logic [2:0] variation; // operation variation
  logic       is_hit;    // hit-type
  logic       is_index;  // index-type
  logic       is_wbi;    // writeback invalidate
  logic       priv_err;  // privilege address error
  logic       low_err;   // low-bit address error
  cmo_va_t    sum_va;    // new effective address

  assign sel       = op[`CMO_OP_SEL_HI:`CMO_OP_SEL_LO];
  assign variation = op[`CMO_OP_VAR_HI:`CMO_OP_VAR_LO];
  assign is_hit    = (variation == `CMO_VAR_HIT_INV) ||
                     (variation == `CMO_VAR_HIT_WBI);
  assign is_index  = !is_hit && (op != `CMO_OP_BARRIER);
  assign is_wbi    = (sel != `CMO_SEL_PI) &&
                     ((variation == `CMO_VAR_IDX_INV) ||
                      (variation == `CMO_VAR_HIT_WBI));

  // sign-extended offset added to base
  assign sum_va = issue.base +
                  {{(`CMO_VA_W-16){issue.offset[`CMO_OFFSET_MSB]}}, issue.offset};

  // user access to the kernel half of the address space
  assign priv_err = !kernel_mode && va[`CMO_PRIV_BIT];
  // bit 0 carries the way on index ops and is exempt
  assign low_err  = is_index ? va[`CMO_LOW_BIT1] :
                    (va[`CMO_LOW_BIT1] || va[`CMO_WAY_BIT]);

  // ----------------------------------------------------------------
  // field selection for the target and for the primary probe
  // ----------------------------------------------------------------
  cmo_idx_t  tgt_index;  // target block
  logic      tgt_way;    // target way
  cmo_word_t tgt_word;   // target word
  cmo_idx_t  prb_index;  // probe block
  logic      prb_way;    // probe way, unused by lookup
  cmo_word_t prb_word;   // probe word, unused by lookup

  cmo_addr_sel #(
    .L2_SIZE_LOG2 (L2_SIZE_LOG2),
    .L2_BLK_LOG2  (L2_BLK_LOG2)
  ) u_tgt_sel (
    .sel   (sel),
    .va    (va),
    .pa    ((state == st_tlb) ? tlb_rsp.pa : pa),
    .index (tgt_index),
    .way   (tgt_way),
    .word  (tgt_word)
  );

  cmo_addr_sel #(
    .L2_SIZE_LOG2 (L2_SIZE_LOG2),
    .L2_BLK_LOG2  (L2_BLK_LOG2)
  ) u_prb_sel (
    .sel   (`CMO_SEL_PD),
    .va    (cmo_va_t'(arr_rsp.tag_addr)),
    .pa    (arr_rsp.tag_addr),
    .index (prb_index),
    .way   (prb_way),
    .word  (prb_word)
  );

  // ----------------------------------------------------------------
  // sequencer next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_op       = op;
    next_va       = va;
    next_pa       = pa;
    next_way      = way;
    next_need_sys = need_sys;
    next_wb       = wb;
    next_exc      = exc;
    next_cmd      = cmd;
    case (state)
      // take a new instruction
      st_idle: begin
        if (issue_valid) begin
          next_op    = issue.op;
          next_va    = sum_va;
          next_exc   = exc_none;
          next_state = st_check;
        end
      end
      // privilege and address checks before translation
      st_check: begin
        if (!kernel_mode && !system_coproc_usable_bit) begin
          next_exc   = exc_cop_unusable;
          next_state = st_done;
        end else if (priv_err || low_err) begin
          next_exc   = exc_addr_err;
          next_state = st_done;
        end else if (op == `CMO_OP_BARRIER) begin
          next_state = st_done;
        end else begin
          next_state = st_tlb;
        end
      end
      // wait for translation
      st_tlb: begin
        if (tlb_rsp_valid) begin
          if (tlb_rsp.refill) begin
            next_exc   = exc_tlb_refill;
            next_state = st_done;
          end else if (tlb_rsp.invalid) begin
            next_exc   = exc_tlb_invalid;
            next_state = st_done;
          end else begin
            next_pa    = tlb_rsp.pa;
            next_state = (is_hit || (is_wbi && sel == `CMO_SEL_PS)) ? st_look : st_act;
          end
        end
      end
      // tag lookup ahead of hit ops and secondary writebacks
      st_look: begin
        if (arr_rsp_valid) begin
          next_way      = is_hit ? arr_rsp.hit_way : cmd.way;
          next_need_sys = arr_rsp.hit && arr_rsp.dirty;
          next_wb       = '{addr: arr_rsp.tag_addr, way: next_way};
          if (is_hit && !arr_rsp.hit) begin
            next_state = st_done;
          end else if (is_wbi && sel == `CMO_SEL_PS && arr_rsp.hit) begin
            next_state = st_probe;
          end else begin
            next_state = st_act;
          end
        end
      end
      // interrogate primary data cache for newer data
      st_probe: begin
        if (arr_rsp_valid) begin
          if (arr_rsp.hit && arr_rsp.dirty) begin
            next_state = st_p2s;
          end else begin
            next_state = need_sys ? st_sys : st_act;
          end
        end
      end
      // primary data written into the secondary cache
      st_p2s: begin
        if (p2s_ack) begin
          if (sel == `CMO_SEL_PS) begin
            next_state = need_sys ? st_sys : st_act;
          end else begin
            next_state = st_done;
          end
        end
      end
      // secondary block out to the system interface
      st_sys: begin
        if (sys_ack) begin
          next_state = st_act;
        end
      end
      // perform the operation on the target block
      st_act: begin
        if (arr_rsp_valid) begin
          if (is_wbi && sel == `CMO_SEL_PD && arr_rsp.dirty) begin
            next_wb    = '{addr: arr_rsp.tag_addr, way: arr_rsp.tag_way};
            next_state = st_p2s;
          end else begin
            next_state = st_done;
          end
        end
      end
      // completion handed back to the pipeline
      st_done: begin
        next_state = st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase

    // array command for the state about to be entered
    if (next_state == st_look) begin
      next_cmd = '{sel: sel, variation: variation, lookup: 1'b1, index: tgt_index,
                   way: tgt_way, word: tgt_word, pa: next_pa};
    end else if (next_state == st_probe) begin
      next_cmd = '{sel: `CMO_SEL_PD, variation: variation, lookup: 1'b1,
                   index: prb_index, way: prb_way, word: prb_word, pa: next_wb.addr};
    end else if (next_state == st_act) begin
      next_cmd = '{sel: sel, variation: variation, lookup: 1'b0, index: tgt_index,
                   way: (is_hit ? next_way : tgt_way), word: tgt_word,
                   pa: next_pa};
    end
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= st_idle;
      op       <= 5'h00;
      va       <= '0;
      pa       <= '0;
      way      <= 1'b0;
      need_sys <= 1'b0;
      wb       <= '0;
      exc      <= exc_none;
      cmd      <= '0;
    end else begin
      state    <= next_state;
      op       <= next_op;
      va       <= next_va;
      pa       <= next_pa;
      way      <= next_way;
      need_sys <= next_need_sys;
      wb       <= next_wb;
      exc      <= next_exc;
      cmd      <= next_cmd;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign issue_ready    = (state == st_idle);
  assign done_valid     = (state == st_done);
  assign done           = '{exc: exc};
  assign watch_suppress = (state != st_idle);
  assign tlb_req_valid  = (state == st_tlb);
  assign tlb_req        = '{va: va, is_store: 1'b0};
  assign arr_req_valid  = (state == st_look) || (state == st_probe) || (state == st_act);
  assign arr_cmd        = cmd;
  assign p2s_valid      = (state == st_p2s);
  assign p2s_wb         = wb;
  assign sys_valid      = (state == st_sys);
  assign sys_wb         = wb;

endmodule // cmo_unit

// File: hw/cmo_regs.svh
`ifndef CMO_REGS_SVH
`define CMO_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CMO_VA_W        64
`define CMO_PA_W        40
`define CMO_IDX_W       20
`define CMO_WORD_W      4

// ----------------------------------------------------------------
// sub-opcode fields and encodings
// ----------------------------------------------------------------
`define CMO_OP_SEL_HI   1
`define CMO_OP_SEL_LO   0
`define CMO_OP_VAR_HI   4
`define CMO_OP_VAR_LO   2
`define CMO_SEL_PI      2'h0
`define CMO_SEL_PD      2'h1
`define CMO_SEL_PS      2'h3
`define CMO_VAR_IDX_INV 3'h0
`define CMO_VAR_LTAG    3'h1
`define CMO_VAR_STAG    3'h2
`define CMO_VAR_HIT_INV 3'h4
`define CMO_VAR_HIT_WBI 3'h5
`define CMO_VAR_LDATA   3'h6
`define CMO_VAR_SDATA   3'h7
`define CMO_OP_BARRIER  5'h14

// ----------------------------------------------------------------
// address bit positions
// ----------------------------------------------------------------
`define CMO_PD_IDX_HI   13
`define CMO_PD_IDX_LO   5
`define CMO_PI_IDX_HI   13
`define CMO_PI_IDX_LO   6
`define CMO_WORD_LO     2
`define CMO_L2_DW_LO    3
`define CMO_WAY_BIT     0
`define CMO_LOW_BIT1    1
`define CMO_PRIV_BIT    63
`define CMO_OFFSET_MSB  15

`endif

// File: hw/cmo_pkg.sv
package cmo_pkg;
  `include "cmo_regs.svh"

  // ----------------------------------------------------------------
  // scalar types
  // ----------------------------------------------------------------
  typedef logic [`CMO_VA_W-1:0]   cmo_va_t;
  typedef logic [`CMO_PA_W-1:0]   cmo_pa_t;
  typedef logic [`CMO_IDX_W-1:0]  cmo_idx_t;
  typedef logic [`CMO_WORD_W-1:0] cmo_word_t;

  // exception reported with completion
  typedef enum logic [2:0] {
    exc_none,
    exc_cop_unusable,
    exc_addr_err,
    exc_tlb_refill,
    exc_tlb_invalid
  } cmo_exc_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  op;      // sub-opcode
    cmo_va_t     base;    // base register contents
    logic [15:0] offset;  // signed offset
  } cmo_issue_s;

  typedef struct packed {
    cmo_va_t va;
    logic    is_store;    // always low: no modify check
  } cmo_tlb_req_s;

  typedef struct packed {
    cmo_pa_t pa;
    logic    refill;
    logic    invalid;
  } cmo_tlb_rsp_s;

  typedef struct packed {
    logic [1:0] sel;       // target cache
    logic [2:0] variation; // operation variation
    logic       lookup;    // 1 = tag lookup only, 0 = perform
    cmo_idx_t   index;
    logic       way;
    cmo_word_t  word;
    cmo_pa_t    pa;        // compare address for lookups
  } cmo_arr_cmd_s;

  typedef struct packed {
    logic    hit;       // valid block (matching for hit lookups)
    logic    hit_way;
    logic    dirty;     // inconsistent (primary) or dirty (secondary)
    cmo_pa_t tag_addr;  // block address held in the tag
    logic    tag_way;   // secondary way held in the tag
  } cmo_arr_rsp_s;

  typedef struct packed {
    cmo_pa_t addr;
    logic    way;
  } cmo_wb_s;

  typedef struct packed {
    cmo_exc_e exc;
  } cmo_done_s;
endpackage

// File: hw/cmo_addr_sel.sv
`timescale 1ns/1ps
module cmo_addr_sel import cmo_pkg::*; #(
  parameter int L2_SIZE_LOG2 = 22,
  parameter int L2_BLK_LOG2  = 7
) (
  // selection
  input  wire logic [1:0] sel,
  input  wire cmo_va_t    va,
  input  wire cmo_pa_t    pa,
  // decoded fields
  output cmo_idx_t        index,
  output logic            way,
  output cmo_word_t       word
);

  // ----------------------------------------------------------------
  // block, way and word selection per target cache
  // ----------------------------------------------------------------
  always_comb begin
    index = '0;
    way   = 1'b0;
    word  = '0;
    case (sel)
      `CMO_SEL_PD: begin
        index = cmo_idx_t'(va[`CMO_PD_IDX_HI:`CMO_PD_IDX_LO]);
        way   = va[`CMO_WAY_BIT];
        word  = cmo_word_t'(va[`CMO_PD_IDX_LO-1:`CMO_WORD_LO]);
      end
      `CMO_SEL_PI: begin
        index = cmo_idx_t'(va[`CMO_PI_IDX_HI:`CMO_PI_IDX_LO]);
        way   = va[`CMO_WAY_BIT];
        word  = cmo_word_t'(va[`CMO_PI_IDX_LO-1:`CMO_WORD_LO]);
      end
      `CMO_SEL_PS: begin
        index = cmo_idx_t'(pa[L2_SIZE_LOG2-1:L2_BLK_LOG2]);
        way   = pa[`CMO_WAY_BIT];
        word  = cmo_word_t'(pa[L2_BLK_LOG2-1:`CMO_L2_DW_LO]);
      end
      default: begin
        // undefined target: fields stay zero
        index = '0;
      end
    endcase
  end

endmodule // cmo_addr_sel

// File: sim/cmo_unit_props.sv
`timescale 1ns/1ps
// --------
// cache op unit checker
// --------
module cmo_unit_props import cmo_pkg::*; #(
  parameter int L2_SIZE_LOG2 = 22,
  parameter int L2_BLK_LOG2  = 7
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         reset_n,
  // pipeline side
  input wire logic         issue_valid,
  input wire logic         issue_ready,
  input wire cmo_issue_s   issue,
  input wire logic         kernel_mode,
  input wire logic         system_coproc_usable_bit,
  input wire logic         done_valid,
  input wire cmo_done_s    done,
  input wire logic         watch_suppress,
  // translation and arrays
  input wire logic         tlb_req_valid,
  input wire cmo_tlb_req_s tlb_req,
  input wire logic         tlb_rsp_valid,
  input wire cmo_tlb_rsp_s tlb_rsp,
  input wire logic         arr_req_valid,
  input wire cmo_arr_cmd_s arr_cmd,
  input wire logic         arr_rsp_valid,
  input wire cmo_arr_rsp_s arr_rsp,
  // system writeback
  input wire logic         sys_valid,
  input wire cmo_wb_s      sys_wb
);
  logic       take;   // op accepted
  logic       chk;    // check cycle
  logic       idx;    // index-type op
  logic       probed; // primary probed for secondary op
  cmo_va_t    ev;     // expected va
  logic [4:0] eop;    // op held
  cmo_pa_t    epa;    // translated pa
  cmo_pa_t    stag;   // secondary tag address

  assign take = issue_valid && issue_ready;
  assign idx  = eop[4:3] != 2'b10;

  // capture of the op under way
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chk    <= 1'b0;
      probed <= 1'b0;
      ev     <= '0;
      eop    <= '0;
      epa    <= '0;
      stag   <= '0;
    end else begin
      chk <= take;
      if (take) begin
        ev     <= issue.base + {{48{issue.offset[15]}}, issue.offset};
        eop    <= issue.op;
        probed <= 1'b0;
      end
      if (tlb_req_valid && tlb_rsp_valid) begin
        epa <= tlb_rsp.pa;
      end
      if (arr_req_valid && arr_rsp_valid && arr_cmd.lookup) begin
        if (arr_cmd.sel == `CMO_SEL_PS) begin
          stag <= arr_rsp.tag_addr;
        end else if (eop[1:0] == `CMO_SEL_PS) begin
          probed <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_cop;
    chk && !kernel_mode && !system_coproc_usable_bit |=> done_valid && done.exc == exc_cop_unusable;
  endproperty
  a_cop: assert property (p_cop) else $error("unusable not refused");
  property p_adi;
    chk && (kernel_mode || system_coproc_usable_bit) && idx && ev[1]
      |=> done_valid && done.exc == exc_addr_err;
  endproperty
  a_adi: assert property (p_adi) else $error("index bit one missed");
  property p_ad0;
    chk && kernel_mode && idx && ev[1:0] == 2'b01 |=> !done_valid && tlb_req_valid;
  endproperty
  a_ad0: assert property (p_ad0) else $error("way bit flagged");
  property p_adn;
    chk && (kernel_mode || system_coproc_usable_bit) && !idx && ev[1:0] != 2'b00
      |=> done_valid && done.exc == exc_addr_err;
  endproperty
  a_adn: assert property (p_adn) else $error("low bits not flagged");
  property p_prv;
    chk && !kernel_mode && system_coproc_usable_bit && ev[63] |=> done.exc == exc_addr_err;
  endproperty
  a_prv: assert property (p_prv) else $error("privilege error missed");
  property p_wch;
    take |=> watch_suppress [*2];
  endproperty
  a_wch: assert property (p_wch) else $error("watch not held off");
  property p_va;
    tlb_req_valid |-> tlb_req.va == ev && !tlb_req.is_store;
  endproperty
  a_va: assert property (p_va) else $error("bad tlb request");
  property p_ref;
    tlb_req_valid && tlb_rsp_valid && tlb_rsp.refill |-> ##[1:2] done.exc == exc_tlb_refill;
  endproperty
  a_ref: assert property (p_ref) else $error("refill not reported");
  property p_sel;
    arr_req_valid && !arr_cmd.lookup |-> arr_cmd.sel == eop[1:0] && arr_cmd.variation == eop[4:2];
  endproperty
  a_sel: assert property (p_sel) else $error("wrong cache or variation");
  property p_pd;
    arr_req_valid && !arr_cmd.lookup && arr_cmd.sel == `CMO_SEL_PD
      |-> arr_cmd.index == cmo_idx_t'(ev[13:5]) && arr_cmd.word == cmo_word_t'(ev[4:2]);
  endproperty
  a_pd: assert property (p_pd) else $error("dcache fields wrong");
  property p_pi;
    arr_req_valid && !arr_cmd.lookup && arr_cmd.sel == `CMO_SEL_PI
      |-> arr_cmd.index == cmo_idx_t'(ev[13:6]) && arr_cmd.word == cmo_word_t'(ev[5:2]);
  endproperty
  a_pi: assert property (p_pi) else $error("icache fields wrong");
  property p_ps;
    arr_req_valid && !arr_cmd.lookup && arr_cmd.sel == `CMO_SEL_PS
      |-> arr_cmd.index == cmo_idx_t'(epa[L2_SIZE_LOG2-1:0] >> L2_BLK_LOG2)
          && arr_cmd.word == cmo_word_t'(epa[L2_BLK_LOG2-1:3]) && (!idx || arr_cmd.way == epa[0]);
  endproperty
  a_ps: assert property (p_ps) else $error("scache fields wrong");
  property p_way;
    arr_req_valid && !arr_cmd.lookup && idx && arr_cmd.sel != `CMO_SEL_PS |-> arr_cmd.way == ev[0];
  endproperty
  a_way: assert property (p_way) else $error("primary way wrong");
  property p_miss;
    arr_req_valid && arr_rsp_valid && arr_cmd.lookup && arr_cmd.sel == eop[1:0]
      && !idx && !arr_rsp.hit |-> ##[1:2] done_valid && done.exc == exc_none;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not quiet");
  property p_sys;
    sys_valid |-> sys_wb.addr == stag && probed;
  endproperty
  a_sys: assert property (p_sys) else $error("sys writeback wrong");
  c_take: cover property (take);
  c_sys: cover property (sys_valid);
  c_miss: cover property (arr_rsp_valid && arr_cmd.lookup && !arr_rsp.hit);
endmodule // cmo_unit_props

bind cmo_unit cmo_unit_props #(.L2_SIZE_LOG2(L2_SIZE_LOG2), .L2_BLK_LOG2(L2_BLK_LOG2)) u_props (.*);

// File: sim/cmo_resp_model.sv
`timescale 1ns/1ps
// --------
// translation, array and writeback responder
// --------
module cmo_resp_model import cmo_pkg::*; (
  // clock
  input  wire logic    clk,
  // behaviour set by the bench
  input  wire logic    m_slow,
  input  wire logic    m_ref,
  input  wire logic    m_inv,
  input  wire logic    m_hit,
  input  wire logic    m_dirty,
  input  wire cmo_pa_t m_pa,
  input  wire cmo_pa_t m_tag,
  // requests
  input  wire logic    tlb_req_valid,
  input  wire logic    arr_req_valid,
  input  wire logic    p2s_valid,
  input  wire logic    sys_valid,
  // answers
  output logic         tlb_rsp_valid,
  output cmo_tlb_rsp_s tlb_rsp,
  output logic         arr_rsp_valid,
  output cmo_arr_rsp_s arr_rsp,
  output logic         p2s_ack,
  output logic         sys_ack
);
  logic [1:0] cnt = 2'h0; // cycles a request has waited
  logic       any;        // some request up
  logic       go;         // answer this cycle

  assign any = tlb_req_valid | arr_req_valid | p2s_valid | sys_valid;
  assign go  = any && (!m_slow || cnt == 2'h2);

  // slow mode answers in the third cycle
  always_ff @(posedge clk) begin
    cnt <= (any && !go) ? cnt + 2'h1 : 2'h0;
  end

  assign tlb_rsp_valid = tlb_req_valid && go;
  assign arr_rsp_valid = arr_req_valid && go;
  assign p2s_ack       = p2s_valid && go;
  assign sys_ack       = sys_valid && go;
  // payloads turn over when not answering
  assign tlb_rsp = tlb_rsp_valid ? {m_pa, m_ref, m_inv} : ~{m_pa, m_ref, m_inv};
  assign arr_rsp = arr_rsp_valid ? {m_hit, 1'b1, m_dirty, m_tag, 1'b1}
                                 : ~{m_hit, 1'b1, m_dirty, m_tag, 1'b1};
endmodule // cmo_resp_model

// File: sim/cmo_unit_tb.sv
`timescale 1ns/1ps
module cmo_unit_tb import cmo_pkg::*;;
  logic         clk = 0;
  logic         reset_n = 0;
  logic         issue_valid = 0;
  logic         kernel_mode = 1;
  logic         system_coproc_usable_bit = 0;
  cmo_issue_s   issue = '0;
  logic         issue_ready, done_valid, watch_suppress, tlb_req_valid, tlb_rsp_valid;
  logic         arr_req_valid, arr_rsp_valid, p2s_valid, p2s_ack, sys_valid, sys_ack;
  cmo_done_s    done;
  cmo_tlb_req_s tlb_req;
  cmo_tlb_rsp_s tlb_rsp;
  cmo_arr_cmd_s arr_cmd;
  cmo_arr_rsp_s arr_rsp;
  cmo_wb_s      p2s_wb, sys_wb;
  logic         m_slow = 0, m_ref = 0, m_inv = 0, m_hit = 0, m_dirty = 0;
  cmo_pa_t      m_pa = 40'hab_cdef_1235, m_tag = 40'h12_3456_7880;
  int           error_cnt = 0, cmp_count = 0, n_p2s, n_sys, n_act, order_ok;
  cmo_pa_t      p2s_a, sys_a;
  cmo_exc_e     e;

  always #4 clk = ~clk;

  cmo_unit u_cmo_unit (.*);
  cmo_resp_model u_cmo_resp_model (.*);

  // writeback and perform monitor
  always @(posedge clk) begin
    if (p2s_valid && p2s_ack) begin
      n_p2s++;
      p2s_a = p2s_wb.addr;
    end
    if (sys_valid && sys_ack) begin
      n_sys++;
      sys_a = sys_wb.addr;
      order_ok = n_p2s;
    end
    if (arr_req_valid && arr_rsp_valid && !arr_cmd.lookup) n_act++;
  end

  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one op, base plus a negative offset
  task automatic run_op(input logic [4:0] op, input cmo_va_t va, input logic k, input logic cu);
    int n = 0;
    n_p2s = 0;
    n_sys = 0;
    n_act = 0;
    order_ok = 0;
    p2s_a = '0;
    @(posedge clk);
    #1;
    issue_valid = 1;
    issue = '{op, va + 64'h0000_0000_0000_0010, 16'hfff0};
    kernel_mode = k;
    system_coproc_usable_bit = cu;
    while (!issue_ready && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    issue_valid = 0;
    n = 0;
    while (!done_valid && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done_valid", 1, done_valid);
    e = done.exc;
    @(posedge clk);
    #1;
  endtask

  task automatic t_priv;
    run_op(5'h00, 64'h1000, 0, 0); check("cop", exc_cop_unusable, e);
    run_op(5'h00, 64'h1000, 0, 1); check("usable", exc_none, e);
    run_op(5'h00, 64'h8000_0000_0000_1000, 0, 1); check("priv", exc_addr_err, e);
  endtask

  task automatic t_align;
    run_op(5'h01, 64'h1001, 1, 0); check("idx_b0", exc_none, e);
    run_op(5'h01, 64'h1002, 1, 0); check("idx_b1", exc_addr_err, e);
    run_op(5'h15, 64'h1001, 1, 0); check("hit_b0", exc_addr_err, e);
    run_op(5'h17, 64'h1002, 1, 0); check("hit_b1", exc_addr_err, e);
  endtask

  task automatic t_tlb;
    m_slow = 1;
    m_ref = 1;
    run_op(5'h11, 64'h2000, 1, 0); check("refill", exc_tlb_refill, e);
    m_inv = 1;
    run_op(5'h03, 64'h2000, 1, 0); check("both", exc_tlb_refill, e);
    m_ref = 0;
    run_op(5'h13, 64'h2000, 1, 0); check("invalid", exc_tlb_invalid, e);
    m_inv = 0;
    m_slow = 0;
  endtask

  task automatic t_hit;
    m_hit = 0;
    run_op(5'h11, 64'h3040, 1, 0); check("miss_exc", exc_none, e);
    check("miss_act", 0, n_act);
    m_hit = 1;
    m_slow = 1;
    run_op(5'h11, 64'h3040, 1, 0); check("hit_act", 1, n_act);
    m_slow = 0;
  endtask

  task automatic t_wb;
    m_hit = 1;
    m_dirty = 1;
    run_op(5'h01, 64'h3fe0, 1, 0); check("dwb_n", 1, n_p2s);
    check("dwb_a", m_tag, p2s_a);
    run_op(5'h15, 64'h3fe0, 1, 0); check("dhwb_a", m_tag, p2s_a);
    run_op(5'h17, 64'h3fe0, 1, 0); check("swb_n", 1, n_sys);
    check("swb_a", m_tag, sys_a);
    check("swb_ord", 1, order_ok);
    m_dirty = 0;
    run_op(5'h17, 64'h3fe0, 1, 0); check("clean_n", 0, n_sys + n_p2s);
  endtask

  // every defined code
  task automatic t_ops;
    logic [1:0] s;
    m_hit = 1;
    for (int i = 0; i < 3; i++) begin
      s = (i == 2) ? 2'h3 : 2'(i);
      for (int v = 0; v < 8; v++) begin
        if (v != 3) begin
          m_pa = ~m_pa;
          run_op({3'(v), s}, 64'h0000_0000_0012_3ac4, 1, 0);
          check("op_exc", exc_none, e);
          check("op_act", ({3'(v), s} != 5'h14), n_act);
        end
      end
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1;
    repeat (3) @(posedge clk);
    t_priv();
    t_align();
    t_tlb();
    t_hit();
    t_wb();
    t_ops();
    complete_run();
  end

  // watchdog
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
endmodule // cmo_unit_tb
